// *** dcac_pkg.sv ***
// constants and types for the four-channel count and address core
package dcac_pkg;
    // register indices; byte address is index times four
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_FLAGS = 8'h03;
    localparam logic [7:0] IDX_STATE = 8'h04;
    localparam logic [7:0] IDX_STAGING_LOW = 8'h06;
    localparam logic [7:0] IDX_STAGING_HIGH = 8'h07;
    localparam logic [3:0] WIN_FIRST = 4'h1;
    localparam logic [3:0] WIN_LAST = 4'h4;
    localparam logic [3:0] CH_CTRL = 4'h0;
    localparam logic [3:0] CH_ADDR = 4'h2;
    localparam logic [3:0] CH_CNTL = 4'h4;
    localparam logic [3:0] CH_CNTH = 4'h5;
    localparam logic [3:0] CH_REP = 4'h6;
    localparam logic [3:0] CH_SRC0 = 4'h8;
    localparam logic [3:0] CH_SRC1 = 4'h9;
    localparam logic [3:0] CH_SRC2 = 4'hA;
    localparam logic [3:0] CH_DST0 = 4'hC;
    localparam logic [3:0] CH_DST1 = 4'hD;
    localparam logic [3:0] CH_DST2 = 4'hE;
    // field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CH_EN_BIT = 7;
    localparam int CH_REP_BIT = 5;
    localparam int CH_TRIG_BIT = 4;
    localparam int ERR_BASE = 4;
    // reset values and counts
    localparam logic [15:0] CNT_RST = 16'h0001;
    localparam logic [15:0] CNT_ZERO_RUN = 16'hFFFF;
    localparam logic [7:0] REP_RST = 8'h00;
    // step and reload codes
    localparam logic [1:0] STEP_HOLD = 2'b00;
    localparam logic [1:0] STEP_INC = 2'b01;
    localparam logic [1:0] STEP_DEC = 2'b10;
    localparam logic [1:0] RLD_BLOCK = 2'b01;
    localparam logic [1:0] RLD_BURST = 2'b10;
    localparam logic [1:0] RLD_TRANS = 2'b11;

    typedef enum logic [2:0] {
        DCAC_IDLE = 3'b001,
        DCAC_READ = 3'b010,
        DCAC_WRITE = 3'b100
    } dcac_phase_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [7:0] wdata;
    } dcac_mem_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dcac_apb_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0][7:0] chctl;
        logic [3:0][7:0] addctl;
        logic [3:0][15:0] cnt;
        logic [3:0][15:0] cnt_rld;
        logic [3:0][7:0] rep;
        logic [3:0][23:0] src;
        logic [3:0][23:0] src_init;
        logic [3:0][23:0] dst;
        logic [3:0][23:0] dst_init;
        logic [15:0] temp;
        logic [7:0] flags;
        logic [3:0] pend;
        dcac_phase_t phase;
        logic [1:0] cur;
        logic [7:0] data;
        dcac_mem_t mem;
        dcac_apb_t apb;
    } dcac_state_t;

    function automatic dcac_state_t reset_state();
        dcac_state_t v;
        v = '0;
        v.cnt = {4{CNT_RST}};
        v.cnt_rld = {4{CNT_RST}};
        v.rep = {4{REP_RST}};
        v.phase = DCAC_IDLE;
        return v;
    endfunction

    localparam dcac_state_t ST_RESET = reset_state();
endpackage

// *** dcac_core.sv ***
// four-channel byte mover: counters, pointers, apb register file
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
//
// Notes on behaviour
// R1: sixteen-bit block byte count per channel
// R2: count drops by one per byte read
// R3: zero count reloads last written value
// R4: count resets to one; zero means 0xFFFF
// R5: repeat counter drops once per block
// R6: repeat count expiry ends the transaction
// R7: repeat count zero repeats without limit
// R8: twenty-four-bit source pointer, byte2 most significant
// R9: source pointer steps by its step mode
// R10: twenty-four-bit target pointer, byte2 most significant
// R11: target pointer steps by its step mode
// R12: count bytes pass through staging register
// R13: pointer bytes pass through staging register
// R14: channel windows at 0x10 to 0x40
// R15: flag register: errors high, done low
// R16: state register: active high, waiting low
// R17: step code fixed while channel active
// R18: pointers reload per block, burst, transaction
// R19: pointer moves one address per byte
// R20: done and error flags stick until cleared
module dcac_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // byte memory master
    output logic mem_req,
    output logic mem_we,
    output logic [23:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic mem_err
);

    function automatic logic mapped(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        if (idx[7:4] == 4'h0)
        begin
            hit = idx == dcac_pkg::IDX_CTRL || idx == dcac_pkg::IDX_FLAGS ||
                  idx == dcac_pkg::IDX_STATE || idx == dcac_pkg::IDX_STAGING_LOW ||
                  idx == dcac_pkg::IDX_STAGING_HIGH;
        end
        else if (idx[7:4] >= dcac_pkg::WIN_FIRST && idx[7:4] <= dcac_pkg::WIN_LAST)
        begin
            hit = idx[3:0] == dcac_pkg::CH_CTRL || idx[3:0] == dcac_pkg::CH_ADDR ||
                  (idx[3:0] >= dcac_pkg::CH_CNTL && idx[3:0] <= dcac_pkg::CH_REP) ||
                  (idx[3:0] >= dcac_pkg::CH_SRC0 && idx[3:0] <= dcac_pkg::CH_SRC2) ||
                  (idx[3:0] >= dcac_pkg::CH_DST0 && idx[3:0] <= dcac_pkg::CH_DST2);
        end
        return hit;
    endfunction

    function automatic logic [23:0] step(input logic [23:0] ptr, input logic [1:0] mode);
        logic [23:0] r;
        r = ptr;
        if (mode == dcac_pkg::STEP_INC)
        begin
            r = ptr + 24'h000001;
        end
        else if (mode == dcac_pkg::STEP_DEC)
        begin
            r = ptr - 24'h000001;
        end
        return r;
    endfunction

    function automatic logic [15:0] load_cnt(input logic [15:0] v);
        return (v == 16'h0000) ? dcac_pkg::CNT_ZERO_RUN : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    dcac_pkg::dcac_state_t st;
    dcac_pkg::dcac_state_t next_st;
    logic [3:0] busy;
    logic [7:0] idx;
    logic [1:0] ch;
    logic setup;
    logic access;
    logic wr_acc;

    assign idx = paddr[9:2];
    assign ch = 2'(idx[5:4] - 2'h1);
    assign setup = psel && !penable;
    assign access = psel && penable && st.apb.pready;
    assign wr_acc = access && pwrite && mapped(idx);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_busy
            assign busy[gi] = st.phase != dcac_pkg::DCAC_IDLE && st.cur == 2'(gi);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [1:0] pick;
        logic found;
        logic last;
        logic [1:0] c;
        pick = 2'h0;
        found = 1'b0;
        last = 1'b0;
        next_st = st;
        c = st.cur;

        // apb: answer prepared in setup, writes land at access edge
        next_st.apb.pready = setup;
        if (setup)
        begin
            next_st.apb.pslverr = !mapped(idx);
            next_st.apb.prdata = 32'h0000_0000;
            if (!pwrite && mapped(idx))
            begin
                if (idx[7:4] == 4'h0)
                begin
                    unique case (idx)
                        dcac_pkg::IDX_CTRL: next_st.apb.prdata[7:0] = st.ctrl;
                        dcac_pkg::IDX_FLAGS: next_st.apb.prdata[7:0] = st.flags; // R15
                        dcac_pkg::IDX_STATE: next_st.apb.prdata[7:0] = {busy, st.pend}; // R16
                        dcac_pkg::IDX_STAGING_LOW: next_st.apb.prdata[7:0] = st.temp[7:0];
                        default: next_st.apb.prdata[7:0] = st.temp[15:8];
                    endcase
                end
                else
                begin
                    // R14
                    unique case (idx[3:0])
                        dcac_pkg::CH_CTRL:
                        begin
                            next_st.apb.prdata[7:0] = st.chctl[ch];
                            next_st.apb.prdata[dcac_pkg::CH_TRIG_BIT] = st.pend[ch];
                        end
                        dcac_pkg::CH_ADDR: next_st.apb.prdata[7:0] = st.addctl[ch];
                        dcac_pkg::CH_CNTL:
                        begin
                            next_st.apb.prdata[7:0] = st.cnt[ch][7:0];
                            next_st.temp[7:0] = st.cnt[ch][15:8]; // R12
                        end
                        dcac_pkg::CH_CNTH: next_st.apb.prdata[7:0] = st.temp[7:0]; // R12
                        dcac_pkg::CH_REP: next_st.apb.prdata[7:0] = st.rep[ch];
                        dcac_pkg::CH_SRC0:
                        begin
                            next_st.apb.prdata[7:0] = st.src[ch][7:0];
                            next_st.temp = st.src[ch][23:8]; // R13
                        end
                        dcac_pkg::CH_SRC1: next_st.apb.prdata[7:0] = st.temp[7:0];
                        dcac_pkg::CH_SRC2: next_st.apb.prdata[7:0] = st.temp[15:8];
                        dcac_pkg::CH_DST0:
                        begin
                            next_st.apb.prdata[7:0] = st.dst[ch][7:0];
                            next_st.temp = st.dst[ch][23:8]; // R13
                        end
                        dcac_pkg::CH_DST1: next_st.apb.prdata[7:0] = st.temp[7:0];
                        default: next_st.apb.prdata[7:0] = st.temp[15:8];
                    endcase
                end
            end
        end

        if (wr_acc)
        begin
            if (idx[7:4] == 4'h0)
            begin
                unique case (idx)
                    dcac_pkg::IDX_CTRL: next_st.ctrl = pwdata[7:0];
                    dcac_pkg::IDX_FLAGS: next_st.flags = st.flags & ~pwdata[7:0]; // R20
                    dcac_pkg::IDX_STATE: next_st.ctrl = st.ctrl;
                    dcac_pkg::IDX_STAGING_LOW: next_st.temp[7:0] = pwdata[7:0];
                    default: next_st.temp[15:8] = pwdata[7:0];
                endcase
            end
            else
            begin
                unique case (idx[3:0])
                    dcac_pkg::CH_CTRL:
                    begin
                        next_st.chctl[ch] = pwdata[7:0];
                        next_st.chctl[ch][dcac_pkg::CH_TRIG_BIT] = 1'b0;
                        if (pwdata[dcac_pkg::CH_TRIG_BIT] && pwdata[dcac_pkg::CH_EN_BIT])
                        begin
                            next_st.pend[ch] = 1'b1;
                        end
                    end
                    dcac_pkg::CH_ADDR:
                    begin
                        if (!busy[ch])
                        begin
                            next_st.addctl[ch] = pwdata[7:0]; // R17
                        end
                    end
                    dcac_pkg::CH_CNTL: next_st.temp[7:0] = pwdata[7:0]; // R12
                    dcac_pkg::CH_CNTH:
                    begin
                        next_st.cnt[ch] = {pwdata[7:0], st.temp[7:0]}; // R1 R12
                        next_st.cnt_rld[ch] = {pwdata[7:0], st.temp[7:0]}; // R3
                    end
                    dcac_pkg::CH_REP: next_st.rep[ch] = pwdata[7:0];
                    dcac_pkg::CH_SRC0: next_st.temp[7:0] = pwdata[7:0];
                    dcac_pkg::CH_SRC1: next_st.temp[15:8] = pwdata[7:0];
                    dcac_pkg::CH_SRC2:
                    begin
                        next_st.src[ch] = {pwdata[7:0], st.temp}; // R8 R13
                        next_st.src_init[ch] = {pwdata[7:0], st.temp};
                    end
                    dcac_pkg::CH_DST0: next_st.temp[7:0] = pwdata[7:0];
                    dcac_pkg::CH_DST1: next_st.temp[15:8] = pwdata[7:0];
                    default:
                    begin
                        next_st.dst[ch] = {pwdata[7:0], st.temp}; // R10 R13
                        next_st.dst_init[ch] = {pwdata[7:0], st.temp};
                    end
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////
        // engine: read a byte, write it, step, count
        unique case (st.phase)
            dcac_pkg::DCAC_IDLE:
            begin
                for (int i = 3; i >= 0; i--)
                begin
                    if (st.pend[i] && st.chctl[i][dcac_pkg::CH_EN_BIT])
                    begin
                        pick = 2'(i);
                        found = 1'b1;
                    end
                end
                if (found && st.ctrl[dcac_pkg::CTRL_EN_BIT])
                begin
                    next_st.cur = pick;
                    next_st.pend[pick] = 1'b0;
                    next_st.cnt[pick] = load_cnt(next_st.cnt[pick]); // R4
                    next_st.phase = dcac_pkg::DCAC_READ;
                end
            end
            dcac_pkg::DCAC_READ:
            begin
                if (mem_ack && mem_err)
                begin
                    next_st.flags[dcac_pkg::ERR_BASE + c] = 1'b1; // R20
                    next_st.chctl[c][dcac_pkg::CH_EN_BIT] = 1'b0;
                    next_st.phase = dcac_pkg::DCAC_IDLE;
                end
                else if (mem_ack)
                begin
                    next_st.data = mem_rdata;
                    next_st.cnt[c] = st.cnt[c] - 16'h0001; // R2
                    next_st.src[c] = step(st.src[c], st.addctl[c][5:4]); // R9 R19
                    if (st.addctl[c][7:6] == dcac_pkg::RLD_BURST)
                    begin
                        next_st.src[c] = st.src_init[c]; // R18
                    end
                    next_st.phase = dcac_pkg::DCAC_WRITE;
                end
            end
            dcac_pkg::DCAC_WRITE:
            begin
                if (mem_ack && mem_err)
                begin
                    next_st.flags[dcac_pkg::ERR_BASE + c] = 1'b1; // R20
                    next_st.chctl[c][dcac_pkg::CH_EN_BIT] = 1'b0;
                    next_st.phase = dcac_pkg::DCAC_IDLE;
                end
                else if (mem_ack)
                begin
                    next_st.dst[c] = step(st.dst[c], st.addctl[c][1:0]); // R11 R19
                    if (st.addctl[c][3:2] == dcac_pkg::RLD_BURST)
                    begin
                        next_st.dst[c] = st.dst_init[c]; // R18
                    end
                    next_st.phase = dcac_pkg::DCAC_READ;
                    if (st.cnt[c] == 16'h0000)
                    begin
                        next_st.cnt[c] = load_cnt(st.cnt_rld[c]); // R3 R4
                        if (st.rep[c] != 8'h00)
                        begin
                            next_st.rep[c] = st.rep[c] - 8'h01; // R5
                        end
                        // R6 R7
                        last = !st.chctl[c][dcac_pkg::CH_REP_BIT] || st.rep[c] == 8'h01;
                        if (st.addctl[c][7:6] == dcac_pkg::RLD_BLOCK ||
                            (last && st.addctl[c][7:6] == dcac_pkg::RLD_TRANS))
                        begin
                            next_st.src[c] = st.src_init[c]; // R18
                        end
                        if (st.addctl[c][3:2] == dcac_pkg::RLD_BLOCK ||
                            (last && st.addctl[c][3:2] == dcac_pkg::RLD_TRANS))
                        begin
                            next_st.dst[c] = st.dst_init[c]; // R18
                        end
                        if (last)
                        begin
                            next_st.flags[c] = 1'b1; // R6 R20
                            next_st.chctl[c][dcac_pkg::CH_EN_BIT] = 1'b0;
                            next_st.phase = dcac_pkg::DCAC_IDLE;
                        end
                    end
                end
            end
        endcase

        next_st.mem.req = next_st.phase != dcac_pkg::DCAC_IDLE;
        next_st.mem.we = next_st.phase == dcac_pkg::DCAC_WRITE;
        next_st.mem.addr = next_st.mem.we ? next_st.dst[next_st.cur] : next_st.src[next_st.cur];
        next_st.mem.wdata = next_st.data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= dcac_pkg::ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.apb.prdata;
    assign pready = st.apb.pready;
    assign pslverr = st.apb.pslverr;
    assign mem_req = st.mem.req;
    assign mem_we = st.mem.we;
    assign mem_addr = st.mem.addr;
    assign mem_wdata = st.mem.wdata;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [15:0] cur_cnt;
    logic [23:0] cur_src;
    logic [23:0] cur_dst;
    logic block_end;
    assign cur_cnt = st.cnt[st.cur];
    assign cur_src = st.src[st.cur];
    assign cur_dst = st.dst[st.cur];
    assign block_end = st.phase == dcac_pkg::DCAC_WRITE && mem_ack && !mem_err &&
                       cur_cnt == 16'h0000 && !wr_acc;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_setup;
        psel && !penable;
    endsequence

    sequence seq_read_ok;
        st.phase == dcac_pkg::DCAC_READ && mem_ack && !mem_err && !wr_acc;
    endsequence

    AST_CNT_DEC: assert property (seq_read_ok |=> cur_cnt == $past(cur_cnt) - 16'h0001) // R2
        else $error("count did not drop after a byte read");
    AST_CNT_RELOAD: assert property (block_end && st.cnt_rld[st.cur] != 16'h0000 // R3
        |=> cur_cnt == $past(st.cnt_rld[st.cur]))
        else $error("count not reloaded at block end");
    AST_ZERO_RUN: assert property (st.phase == dcac_pkg::DCAC_IDLE && // R4
        next_st.phase == dcac_pkg::DCAC_READ && st.cnt[next_st.cur] == 16'h0000
        |=> cur_cnt == 16'hFFFF)
        else $error("zero count did not start a full run");
    AST_REP_END: assert property (block_end && st.chctl[st.cur][dcac_pkg::CH_REP_BIT] && // R6
        st.rep[st.cur] == 8'h01 |=> st.phase == dcac_pkg::DCAC_IDLE &&
        st.flags[st.cur] && !st.chctl[st.cur][dcac_pkg::CH_EN_BIT])
        else $error("repeat expiry did not end transaction");
    AST_REP_FOREVER: assert property (block_end && st.chctl[st.cur][dcac_pkg::CH_REP_BIT] && // R7
        st.rep[st.cur] == 8'h00 |=> st.phase == dcac_pkg::DCAC_READ ##1 mem_req)
        else $error("unlimited repeat stopped");
    AST_SRC_INC: assert property (seq_read_ok and (st.addctl[st.cur][5:4] == // R9
        dcac_pkg::STEP_INC && st.addctl[st.cur][7:6] != dcac_pkg::RLD_BURST)
        |=> cur_src == $past(cur_src) + 24'h000001)
        else $error("source pointer did not step up");
    AST_DST_DEC: assert property (st.phase == dcac_pkg::DCAC_WRITE && mem_ack && // R11
        !mem_err && !wr_acc && cur_cnt != 16'h0000 && st.addctl[st.cur][3:0] ==
        {2'b00, dcac_pkg::STEP_DEC} |=> cur_dst == $past(cur_dst) - 24'h000001)
        else $error("target pointer did not step down");
    AST_STEP_LOCK: assert property (wr_acc && idx[3:0] == dcac_pkg::CH_ADDR && // R17
        idx[7:4] != 4'h0 && busy[ch] |=> $stable(st.addctl))
        else $error("step code changed while active");
    AST_ERR_FLAG: assert property (st.phase != dcac_pkg::DCAC_IDLE && mem_ack && mem_err // R20
        |=> st.flags[dcac_pkg::ERR_BASE + st.cur] && st.phase == dcac_pkg::DCAC_IDLE)
        else $error("error flag not raised");
    AST_APB_ANSWER: assert property (seq_setup |=> pready ##1 !pready || (psel && !penable)) // pready one cycle after setup, low the cycle after unless a new setup
        else $error("apb answer timing broken");
endmodule

// *** dcac_mem_model.sv ***
// byte memory partner with wait states and injected error
`timescale 1ns/100ps
module dcac_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // byte bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    output logic mem_err,
    // scenario controls
    input wire logic [1:0] wait_cycles,
    input wire logic err_on,
    input wire logic [23:0] err_addr
);
    logic [1:0] cnt;
    int wr_n;
    logic [23:0] wr_a;
    logic [7:0] wr_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 2'h0;
            wr_n <= 0;
            wr_a <= 24'h0;
            wr_d <= 8'h00;
            mem_rdata <= 8'h00;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
        end
        else if (mem_req && !mem_ack && cnt == wait_cycles)
        begin
            cnt <= 2'h0;
            mem_ack <= 1'b1;
            mem_err <= err_on && mem_addr == err_addr;
            mem_rdata <= mem_addr[7:0] ^ 8'h5A;
            if (mem_we)
            begin
                wr_n <= wr_n + 1;
                wr_a <= mem_addr;
                wr_d <= mem_wdata;
            end
        end
        else
        begin
            // read data is meaningless outside the ack cycle
            cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** tb_top.sv ***
// register-level test of the count and address core
`timescale 1ns/100ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic mem_req, mem_we, mem_ack, mem_err, err_on;
    logic [23:0] mem_addr, err_addr;
    logic [7:0] mem_wdata, mem_rdata, q;
    logic [1:0] wait_cycles;
    int err_count, tests_run, n0;

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    dcac_core dcac_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata, .mem_ack, .mem_err);
    dcac_mem_model dcac_mem_model_inst (.pclk, .presetn, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack, .mem_err, .wait_cycles, .err_on, .err_addr);

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            wrap_up();
        end
        q = prdata[7:0];
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [9:0] ca(input logic [3:0] w, input logic [3:0] off);
        return {w, off, 2'b00};
    endfunction

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    // pointer bytes low to high, byte2 commits
    task automatic set_ptr(input logic [3:0] w, input logic [3:0] b, input logic [23:0] v);
        wr(ca(w, b), v[7:0]);
        wr(ca(w, b + 4'h1), v[15:8]);
        wr(ca(w, b + 4'h2), v[23:16]);
    endtask

    task automatic set_cnt(input logic [3:0] w, input logic [15:0] v);
        wr(ca(w, dcac_pkg::CH_CNTL), v[7:0]);
        wr(ca(w, dcac_pkg::CH_CNTH), v[15:8]);
    endtask

    task automatic poll(input logic [7:0] m);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, {dcac_pkg::IDX_FLAGS, 2'b00}, 8'h00);
            n++;
        end
        while ((q & m) !== m && n < 100);
        if ((q & m) !== m)
        begin
            err_count++;
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        wait_cycles = 2'h0;
        err_on = 1'b0;
        err_addr = 24'h000300;
        err_count = 0;
        tests_run = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ca(4'h1, dcac_pkg::CH_CNTL), 8'h01);
        rd(ca(4'h1, dcac_pkg::CH_CNTH), 8'h00);
        rd(ca(4'h1, dcac_pkg::CH_REP), 8'h00);
        rd(ca(4'h4, dcac_pkg::CH_DST0), 8'h00);
        rd(ca(4'h1, 4'h7), 8'h00);
        chk(perr, 1'b1);
        wr({dcac_pkg::IDX_CTRL, 2'b00}, 8'h80);
        rd({dcac_pkg::IDX_CTRL, 2'b00}, 8'h80);
        $display("test reset done");
        // src up, dst down, three bytes
        set_ptr(4'h1, dcac_pkg::CH_SRC0, 24'h012345);
        set_ptr(4'h1, dcac_pkg::CH_DST0, 24'h0A0000);
        wr(ca(4'h1, dcac_pkg::CH_ADDR), 8'h12);
        set_cnt(4'h1, 16'h0003);
        n0 = dcac_mem_model_inst.wr_n;
        wr(ca(4'h1, dcac_pkg::CH_CTRL), 8'h90);
        poll(8'h01);
        chk(32'(dcac_mem_model_inst.wr_n - n0), 32'd3);
        chk(dcac_mem_model_inst.wr_a, 24'h09FFFE);
        chk(dcac_mem_model_inst.wr_d, 8'h1D);
        rd({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h01);
        rd(ca(4'h1, dcac_pkg::CH_SRC0), 8'h48);
        rd(ca(4'h1, dcac_pkg::CH_SRC1), 8'h23);
        rd(ca(4'h1, dcac_pkg::CH_SRC2), 8'h01);
        rd(ca(4'h1, dcac_pkg::CH_CNTL), 8'h03);
        rd(ca(4'h1, dcac_pkg::CH_CNTH), 8'h00);
        wr({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h01);
        rd({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h00);
        $display("test steps done");
        // slow memory, two blocks of two, dst reload per block
        wait_cycles <= 2'h3;
        set_ptr(4'h2, dcac_pkg::CH_SRC0, 24'h000100);
        set_ptr(4'h2, dcac_pkg::CH_DST0, 24'h000200);
        wr(ca(4'h2, dcac_pkg::CH_ADDR), 8'h05);
        set_cnt(4'h2, 16'h0002);
        wr(ca(4'h2, dcac_pkg::CH_REP), 8'h02);
        n0 = dcac_mem_model_inst.wr_n;
        wr(ca(4'h2, dcac_pkg::CH_CTRL), 8'hB0);
        wr(ca(4'h2, dcac_pkg::CH_ADDR), 8'h00);
        rd(ca(4'h2, dcac_pkg::CH_ADDR), 8'h05);
        rd({dcac_pkg::IDX_STATE, 2'b00}, 8'h20);
        poll(8'h02);
        chk(32'(dcac_mem_model_inst.wr_n - n0), 32'd4);
        chk(dcac_mem_model_inst.wr_a, 24'h000201);
        chk(dcac_mem_model_inst.wr_d, 8'h5A);
        rd(ca(4'h2, dcac_pkg::CH_REP), 8'h00);
        rd(ca(4'h2, dcac_pkg::CH_DST0), 8'h00);
        rd(ca(4'h2, dcac_pkg::CH_DST1), 8'h02);
        rd(ca(4'h2, dcac_pkg::CH_DST2), 8'h00);
        wr({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h02);
        $display("test repeat done");
        // failing read on channel 2
        wait_cycles <= 2'h0;
        err_on <= 1'b1;
        set_ptr(4'h3, dcac_pkg::CH_SRC0, 24'h000300);
        set_cnt(4'h3, 16'h0001);
        wr(ca(4'h3, dcac_pkg::CH_CTRL), 8'h90);
        poll(8'h40);
        rd({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h40);
        wr({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h40);
        rd({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h00);
        err_on <= 1'b0;
        $display("test error done");
        // repeat count zero: blocks of one byte never end
        set_cnt(4'h4, 16'h0001);
        wr(ca(4'h4, dcac_pkg::CH_CTRL), 8'hB0);
        repeat (40) @(posedge pclk);
        rd({dcac_pkg::IDX_STATE, 2'b00}, 8'h80);
        rd({dcac_pkg::IDX_FLAGS, 2'b00}, 8'h00);
        $display("test unlimited done");
        wrap_up();
    end
endmodule
